// *** rtl/tlc_pkg.sv ***
package tlc_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CORE_PERIOD_NS = 5;
	localparam int CORE_FREQ_KHZ = 200000;
	localparam int MCLK_LOSS_NS = 1000000;
	localparam int MCLK_LOSS_CYCLES = MCLK_LOSS_NS / CORE_PERIOD_NS;
	localparam int HW_RST_MIN_NS = 2000;
	localparam int HW_RST_CYCLES = (HW_RST_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int PD_RECOVER_NS = 1000000;
	localparam int PD_RECOVER_CYCLES = (PD_RECOVER_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam logic [17:0] LINE_RATE_CLOCK_T1_KHZ = 18'h00608;
	localparam logic [17:0] LINE_RATE_CLOCK_E1_KHZ = 18'h00800;
	localparam logic [17:0] LINE_RATE_CLOCK_MOD_KHZ = 18'h30D40;
	localparam logic [6:0] TCLK_LOSS_TICKS = 7'h40;

	// ****************************************************************
	// pin synchroniser bit positions
	// ****************************************************************
	localparam int PIN_OE = 0;
	localparam int PIN_HWRST_N = 1;
	localparam int PIN_MCLK = 2;
	localparam int PIN_OC = 3;
	localparam int PIN_TCLK = 4;
	localparam int PIN_POS = 5;
	localparam int PIN_NEG = 6;
	localparam int PIN_COUNT = 7;

	// ****************************************************************
	// configuration codes and reset values
	// ****************************************************************
	localparam logic [2:0] TERM_COAX_INTERNAL = 3'h3;
	localparam logic [2:0] TERM_E1_EXTERNAL = 3'h7;
	localparam logic [2:0] TERM_TP_INTERNAL_MAX = 3'h6;
	localparam logic [4:0] SAMPLE_FIRST = 5'h01;
	localparam logic [4:0] SAMPLE_LAST = 5'h14;
	localparam logic [6:0] SAMPLE_RESET = 7'h00;

	typedef enum logic [1:0] {
		TLC_FMT_SINGLE_NRZ = 2'h0,
		TLC_FMT_DUAL_NRZ = 2'h1,
		TLC_FMT_DUAL_RZ = 2'h2
	} tlc_format_t;

	typedef enum logic [2:0] {
		TLC_PWR_ACTIVE = 3'h1,
		TLC_PWR_OFF = 3'h2,
		TLC_PWR_SETTLE = 3'h4
	} tlc_pwr_state_t;

	// ****************************************************************
	// standard transmit templates, sample 1 first
	// ****************************************************************
	typedef logic [0:19][6:0] tlc_tmpl_t;

	localparam tlc_tmpl_t TMPL_T1_SHORT = {7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25,
		7'h24, 7'h23, 7'h4A, 7'h4A, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00, 7'h00};
	localparam tlc_tmpl_t TMPL_T1_266 = {7'h1B, 7'h2E, 7'h2C, 7'h2A, 7'h29, 7'h28, 7'h27,
		7'h26, 7'h25, 7'h50, 7'h4F, 7'h4D, 7'h4A, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00};
	localparam tlc_tmpl_t TMPL_T1_399 = {7'h1F, 7'h34, 7'h2F, 7'h2C, 7'h2B, 7'h2A, 7'h29,
		7'h28, 7'h25, 7'h57, 7'h53, 7'h50, 7'h4B, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00};
	localparam tlc_tmpl_t TMPL_T1_533 = {7'h20, 7'h3B, 7'h35, 7'h2F, 7'h2E, 7'h2D, 7'h2C,
		7'h2A, 7'h28, 7'h58, 7'h58, 7'h53, 7'h4C, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00};
	localparam tlc_tmpl_t TMPL_T1_655 = {7'h20, 7'h3F, 7'h38, 7'h33, 7'h2F, 7'h2E, 7'h2D,
		7'h2C, 7'h29, 7'h5F, 7'h5E, 7'h57, 7'h4F, 7'h49, 7'h47, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00};
	localparam tlc_tmpl_t TMPL_E1_75 = {7'h00, 7'h00, 7'h00, 7'h0C, 7'h30, 7'h00, 7'h00,
		7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
	localparam tlc_tmpl_t TMPL_E1_120 = {7'h00, 7'h00, 7'h00, 7'h0F, 7'h3C, 7'h00, 7'h00,
		7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};

	// index is the low three bits of the template select code
	localparam tlc_tmpl_t TMPL_TABLE [8] = '{TMPL_E1_75, TMPL_E1_120, TMPL_T1_SHORT, TMPL_T1_266,
		TMPL_T1_399, TMPL_T1_533, TMPL_T1_655, TMPL_T1_SHORT};

endpackage

// *** rtl/tlc_rom_if.sv ***
`timescale 1ns/1ps
interface tlc_rom_if;
	logic [2:0] template_sel;
	logic [4:0] sample_index;
	logic [6:0] sample_value;

	modport requester
	(
		output template_sel,
		output sample_index,
		input sample_value
	);

	modport rom
	(
		input template_sel,
		input sample_index,
		output sample_value
	);
endinterface

// *** rtl/tlc_template_rom.sv ***
`timescale 1ns/1ps
module tlc_template_rom
(
	input wire logic core_clk,
	input wire logic rst,
	tlc_rom_if.rom rom_port
);

	// ****************************************************************
	// registered read of the fixed sample table
	// ****************************************************************
	function automatic logic [6:0] tlc_lookup(input logic [2:0] sel, input logic [4:0] idx);
		logic [6:0] v;
		v = tlc_pkg::SAMPLE_RESET;
		if (idx >= tlc_pkg::SAMPLE_FIRST && idx <= tlc_pkg::SAMPLE_LAST)
			v = tlc_pkg::TMPL_TABLE[sel][idx - tlc_pkg::SAMPLE_FIRST];
		return v;
	endfunction

	always_ff @(posedge core_clk)
	begin
		if (rst)
			rom_port.sample_value <= tlc_pkg::SAMPLE_RESET;
		else
			rom_port.sample_value <= tlc_lookup(rom_port.template_sel, rom_port.sample_index);
	end

	default clocking rom_cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_j1_matches_t1: assert property (
		rom_port.template_sel == 3'h7 |=>
		rom_port.sample_value == tlc_lookup(3'h2, $past(rom_port.sample_index)))
		else $error("j1 template differs from shortest t1 template");

endmodule

// *** rtl/tlc_line_driver.sv ***
`timescale 1ns/1ps
module tlc_line_driver
#(
	parameter int MCLK_LOSS_CYCLES = tlc_pkg::MCLK_LOSS_CYCLES,
	parameter int PD_RECOVER_CYCLES = tlc_pkg::PD_RECOVER_CYCLES
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic output_enable_pin,
	input wire logic hw_reset_pin_n,
	input wire logic global_soft_reset,
	input wire logic mclk_watch_in,
	input wire logic channel_soft_reset,
	input wire logic driver_enable,
	input wire logic overcurrent_hiz_select,
	input wire logic single_ended_select,
	input wire logic tx_power_down,
	input wire logic [2:0] termination_code,
	input wire logic e1_mode,
	input wire logic [1:0] tx_format,
	input wire logic remote_loopback,
	input wire logic internal_pattern_line_rate_clock,
	input wire logic overcurrent_edge_select,
	input wire logic overcurrent_irq_mask,
	input wire logic overcurrent_irq_clear,
	input wire logic tmf_show_overcurrent,
	input wire logic tx_overcurrent,
	input wire logic tx_system_clock,
	input wire logic tx_positive_rail_in,
	input wire logic tx_negative_rail_in,
	input wire logic [3:0] pulse_template_select,
	input wire logic [4:0] sample_index,
	output logic line_tip_out,
	output logic line_tip_oe,
	output logic line_ring_out,
	output logic line_ring_oe,
	output logic tx_multifunction_out,
	output logic tx_multifunction_oe,
	output logic tx_current_limit,
	output logic overcurrent_live_status,
	output logic overcurrent_irq_status,
	output logic irq_n,
	output logic tx_clock_loss_status,
	output logic mclk_loss_status,
	output logic tx_settling,
	output logic config_error,
	output logic [6:0] sample_value
);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [tlc_pkg::PIN_COUNT-1:0] pin_raw;
	logic [tlc_pkg::PIN_COUNT-1:0] pin_s1_q;
	logic [tlc_pkg::PIN_COUNT-1:0] pin_s2_q;
	logic [tlc_pkg::PIN_COUNT-1:0] pin_s3_q;

	assign pin_raw = {tx_negative_rail_in, tx_positive_rail_in, tx_system_clock, tx_overcurrent,
		mclk_watch_in, hw_reset_pin_n, output_enable_pin};

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
		end
		else
		begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	logic oe_pin_s;
	logic oc_s;
	logic mclk_edge;
	logic tclk_edge;

	assign oe_pin_s = pin_s2_q[tlc_pkg::PIN_OE];
	assign oc_s = pin_s2_q[tlc_pkg::PIN_OC];
	assign mclk_edge = pin_s2_q[tlc_pkg::PIN_MCLK] ^ pin_s3_q[tlc_pkg::PIN_MCLK];
	assign tclk_edge = pin_s2_q[tlc_pkg::PIN_TCLK] ^ pin_s3_q[tlc_pkg::PIN_TCLK];

	// ****************************************************************
	// master clock activity watch
	// ****************************************************************
	logic [17:0] mclk_idle_q;
	logic mclk_loss_q;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			mclk_idle_q <= '0;
		else if (mclk_edge)
			mclk_idle_q <= '0;
		else if (!mclk_loss_q)
			mclk_idle_q <= mclk_idle_q + 18'h00001;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			mclk_loss_q <= 1'b0;
		else
			mclk_loss_q <= !mclk_edge && (mclk_idle_q >= 18'(MCLK_LOSS_CYCLES));
	end

	// ****************************************************************
	// reset events
	// ****************************************************************
	logic [9:0] hwrst_low_q;
	logic hwrst_long;
	logic drv_en_prev_q;
	logic reset_hiz_q;

	assign hwrst_long = hwrst_low_q > 10'(tlc_pkg::HW_RST_CYCLES);

	always_ff @(posedge core_clk)
	begin
		if (rst)
			hwrst_low_q <= '0;
		else if (pin_s2_q[tlc_pkg::PIN_HWRST_N])
			hwrst_low_q <= '0;
		else if (!hwrst_long)
			hwrst_low_q <= hwrst_low_q + 10'h001;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			drv_en_prev_q <= 1'b1;
		else
			drv_en_prev_q <= driver_enable;
	end

	// held until software enables the driver afresh; a new event beats the release
	always_ff @(posedge core_clk)
	begin
		if (rst)
			reset_hiz_q <= 1'b1;
		else if (hwrst_long || global_soft_reset || channel_soft_reset)
			reset_hiz_q <= 1'b1;
		else if (driver_enable && !drv_en_prev_q)
			reset_hiz_q <= 1'b0;
	end

	// ****************************************************************
	// line-rate tick and tx clock loss
	// ****************************************************************
	logic [17:0] line_rate_clock_acc_q;
	logic [17:0] line_rate_clock_sum;
	logic line_rate_clock_tick;
	logic [6:0] tclk_idle_q;
	logic tclk_watch;
	logic tclk_loss_q;
	tlc_pkg::tlc_pwr_state_t pwr_q;
	tlc_pkg::tlc_pwr_state_t pwr_d;
	logic [17:0] settle_q;

	assign line_rate_clock_sum = line_rate_clock_acc_q + (e1_mode ? tlc_pkg::LINE_RATE_CLOCK_E1_KHZ : tlc_pkg::LINE_RATE_CLOCK_T1_KHZ);
	assign line_rate_clock_tick = line_rate_clock_sum >= tlc_pkg::LINE_RATE_CLOCK_MOD_KHZ;
	assign tclk_watch = (tx_format == tlc_pkg::TLC_FMT_SINGLE_NRZ
		|| tx_format == tlc_pkg::TLC_FMT_DUAL_NRZ) && !remote_loopback && !internal_pattern_line_rate_clock;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			line_rate_clock_acc_q <= '0;
		else if (line_rate_clock_tick)
			line_rate_clock_acc_q <= line_rate_clock_sum - tlc_pkg::LINE_RATE_CLOCK_MOD_KHZ;
		else
			line_rate_clock_acc_q <= line_rate_clock_sum;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || tclk_edge || !tclk_watch || pwr_q != tlc_pkg::TLC_PWR_ACTIVE)
			tclk_idle_q <= '0;
		else if (line_rate_clock_tick && !tclk_loss_q)
			tclk_idle_q <= tclk_idle_q + 7'h01;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			tclk_loss_q <= 1'b0;
		else
			tclk_loss_q <= tclk_idle_q > tlc_pkg::TCLK_LOSS_TICKS;
	end

	// ****************************************************************
	// power down and recovery
	// ****************************************************************
	always_comb
	begin
		pwr_d = pwr_q;
		case (pwr_q)
			tlc_pkg::TLC_PWR_ACTIVE:
				if (tx_power_down)
					pwr_d = tlc_pkg::TLC_PWR_OFF;
			tlc_pkg::TLC_PWR_OFF:
				if (!tx_power_down)
					pwr_d = tlc_pkg::TLC_PWR_SETTLE;
			tlc_pkg::TLC_PWR_SETTLE:
				if (tx_power_down)
					pwr_d = tlc_pkg::TLC_PWR_OFF;
				else if (settle_q == 18'h00001)
					pwr_d = tlc_pkg::TLC_PWR_ACTIVE;
			default:
				pwr_d = tlc_pkg::TLC_PWR_OFF;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			pwr_q <= tlc_pkg::TLC_PWR_ACTIVE;
		else
			pwr_q <= pwr_d;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || pwr_q == tlc_pkg::TLC_PWR_OFF)
			settle_q <= 18'(PD_RECOVER_CYCLES);
		else if (pwr_q == tlc_pkg::TLC_PWR_SETTLE)
			settle_q <= settle_q - 18'h00001;
	end

	// ****************************************************************
	// over-current status and interrupt
	// ****************************************************************
	logic oc_live_q;
	logic oc_irq_q;
	logic oc_event;

	assign oc_event = overcurrent_edge_select ? (oc_s != oc_live_q) : (oc_s && !oc_live_q);

	always_ff @(posedge core_clk)
	begin
		if (rst)
			oc_live_q <= 1'b0;
		else
			oc_live_q <= oc_s;
	end

	// a new edge wins over a clear in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (rst)
			oc_irq_q <= 1'b0;
		else if (oc_event)
			oc_irq_q <= 1'b1;
		else if (overcurrent_irq_clear)
			oc_irq_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			irq_n <= 1'b1;
		else
			irq_n <= !(oc_irq_q && !overcurrent_irq_mask);
	end

	assign overcurrent_live_status = oc_live_q;
	assign overcurrent_irq_status = oc_irq_q;

	// ****************************************************************
	// high impedance decision and line outputs
	// ****************************************************************
	logic hiz_d;
	logic pd_active;
	logic tip_d;
	logic ring_d;

	assign pd_active = pwr_q != tlc_pkg::TLC_PWR_ACTIVE;
	assign hiz_d = !oe_pin_s || !driver_enable || mclk_loss_q || reset_hiz_q || tclk_loss_q
		|| pd_active || (oc_s && overcurrent_hiz_select);

	// rail data is zeroed while the transmitter is off
	always_comb
	begin
		tip_d = 1'b0;
		ring_d = 1'b0;
		if (!pd_active)
		begin
			tip_d = pin_s2_q[tlc_pkg::PIN_POS];
			if (tx_format != tlc_pkg::TLC_FMT_SINGLE_NRZ)
				ring_d = pin_s2_q[tlc_pkg::PIN_NEG];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			line_tip_oe <= 1'b0;
			line_ring_oe <= 1'b0;
			line_tip_out <= 1'b0;
			line_ring_out <= 1'b0;
		end
		else
		begin
			line_tip_oe <= !hiz_d;
			line_ring_oe <= !hiz_d && !single_ended_select;
			line_tip_out <= tip_d;
			line_ring_out <= ring_d;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			tx_current_limit <= 1'b0;
		else
			tx_current_limit <= oc_s && !overcurrent_hiz_select;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			tx_multifunction_out <= 1'b0;
			tx_multifunction_oe <= 1'b0;
		end
		else
		begin
			tx_multifunction_out <= tmf_show_overcurrent && oc_s;
			tx_multifunction_oe <= !pd_active;
		end
	end

	// ****************************************************************
	// status outputs and configuration check
	// ****************************************************************
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			tx_clock_loss_status <= 1'b0;
			mclk_loss_status <= 1'b0;
			tx_settling <= 1'b0;
			config_error <= 1'b0;
		end
		else
		begin
			tx_clock_loss_status <= tclk_loss_q;
			mclk_loss_status <= mclk_loss_q;
			tx_settling <= pwr_q == tlc_pkg::TLC_PWR_SETTLE;
			config_error <= (single_ended_select
				&& termination_code != tlc_pkg::TERM_COAX_INTERNAL)
				|| (!e1_mode && termination_code == tlc_pkg::TERM_E1_EXTERNAL);
		end
	end

	// ****************************************************************
	// template read port
	// ****************************************************************
	tlc_rom_if rom_bus ();

	assign rom_bus.template_sel = pulse_template_select[2:0];
	assign rom_bus.sample_index = sample_index;
	assign sample_value = rom_bus.sample_value;

	tlc_template_rom u_rom
	(
		.core_clk(core_clk),
		.rst(rst),
		.rom_port(rom_bus.rom)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking drv_cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_global_pin_hiz: assert property (!oe_pin_s |=> !line_tip_oe && !line_ring_oe)
		else $error("line driven while enable pin low");

	a_channel_enable_hiz: assert property (!driver_enable |=> !line_tip_oe)
		else $error("line driven while channel enable off");

	a_oc_select_action: assert property (
		oc_s |=> (tx_current_limit != $past(overcurrent_hiz_select))
		&& ($past(overcurrent_hiz_select) -> !line_tip_oe))
		else $error("over-current response wrong");

	a_oc_edge_sticky: assert property (
		(oc_s && !oc_live_q) ##1 !overcurrent_irq_clear [*2] |-> oc_irq_q)
		else $error("over-current edge not latched");

	a_irq_out_level: assert property (
		oc_irq_q && !overcurrent_irq_mask |=> !irq_n)
		else $error("interrupt not asserted");

	a_single_ended_ring: assert property (single_ended_select |=> !line_ring_oe)
		else $error("ring driven in single-ended mode");

	a_power_down_off: assert property (
		tx_power_down ##1 tx_power_down |=> !tx_multifunction_oe && !line_tip_oe && !line_tip_out)
		else $error("transmitter active in power down");

	a_settle_holds_hiz: assert property (
		$fell(tx_power_down) ##1 !tx_power_down [*3] |-> tx_settling && !line_tip_oe)
		else $error("recovery time not kept");

	a_tclk_loss_hiz: assert property (tclk_loss_q |=> !line_tip_oe)
		else $error("line driven during tx clock loss");

	a_soft_reset_hiz: assert property (
		channel_soft_reset ##1 !(driver_enable && !drv_en_prev_q) |=> !line_tip_oe)
		else $error("line driven after channel reset");

endmodule

// *** tb/tlc_line_load.sv ***
`timescale 1ns/1ps
module tlc_line_load
(
	input wire logic core_clk,
	input wire logic tip,
	input wire logic tip_oe,
	input wire logic ring,
	input wire logic ring_oe,
	input wire logic short_req,
	output logic tx_overcurrent,
	output logic tip_level,
	output logic ring_level
);
	// ********************************
	// over-current sense and line levels
	// ********************************
	// a shorted pair keeps the sense tripped while the short stands
	assign tx_overcurrent = short_req;
	// an undriven winding floats: inverse of the last level, changing every cycle
	always_ff @(posedge core_clk)
	begin
		tip_level <= tip_oe ? tip : ~tip_level;
		ring_level <= ring_oe ? ring : ~ring_level;
	end
endmodule

// *** tb/tlc_line_driver_tb_top.sv ***
`timescale 1ns/1ps
module tlc_line_driver_tb_top;
	// ********************************
	// signals
	// ********************************
	localparam int MCLK_LIM = 50;
	localparam int PD_LIM = 20;
	localparam int KHZ = tlc_pkg::CORE_FREQ_KHZ;
	localparam logic [159:0] TMPL [8] = '{{40'h0000000C30, 120'h0}, {40'h0000000F3C, 120'h0},
		160'h1727272625252524234A4A494745444342410000,
		160'h1B2E2C2A2928272625504F4D4A48464443424100,
		160'h1F342F2C2B2A2928255753504B48464443424100,
		160'h203B352F2E2D2C2A285858534C48464443424100,
		160'h203F38332F2E2D2C295F5E574F49474443424100,
		160'h1727272625252524234A4A494745444342410000};
	logic core_clk, rst, output_enable_pin, hw_reset_pin_n, global_soft_reset, mclk_watch_in;
	logic channel_soft_reset, driver_enable, overcurrent_hiz_select, single_ended_select;
	logic tx_power_down, e1_mode, remote_loopback, internal_pattern_line_rate_clock, overcurrent_edge_select;
	logic overcurrent_irq_mask, overcurrent_irq_clear, tmf_show_overcurrent, tx_overcurrent;
	logic tx_system_clock, tx_positive_rail_in, tx_negative_rail_in;
	logic [2:0] termination_code;
	logic [1:0] tx_format;
	logic [3:0] pulse_template_select;
	logic [4:0] sample_index;
	logic line_tip_out, line_tip_oe, line_ring_out, line_ring_oe, tx_multifunction_out;
	logic tx_multifunction_oe, tx_current_limit, overcurrent_live_status, overcurrent_irq_status;
	logic irq_n, tx_clock_loss_status, mclk_loss_status, tx_settling, config_error;
	logic [6:0] sample_value;
	logic short_req, mclk_run, tclk_run;
	logic [1:0] tclk_div;
	int n_errors, n_checks, cnt, lo, hi;

	tlc_line_driver #(.MCLK_LOSS_CYCLES(MCLK_LIM), .PD_RECOVER_CYCLES(PD_LIM)) u_dut (.*);

	tlc_line_load u_load (.core_clk(core_clk), .tip(line_tip_out), .tip_oe(line_tip_oe),
		.ring(line_ring_out), .ring_oe(line_ring_oe), .short_req(short_req),
		.tx_overcurrent(tx_overcurrent), .tip_level(), .ring_level());

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		if (mclk_run)
			mclk_watch_in <= ~mclk_watch_in;
		tclk_div <= tclk_div + 2'h1;
		if (tclk_run && tclk_div == 2'h3)
			tx_system_clock <= ~tx_system_clock;
	end

	// ********************************
	// helpers
	// ********************************
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_val(ref logic s, input logic v, input int lim, output int c);
		c = 0;
		n_checks++;
		while (s !== v && c < lim)
		begin
			@(negedge core_clk);
			c++;
		end
		if (s !== v)
		begin
			n_errors++;
			$display("unexpected at %0t: wait ran out, seen %h expected %h", $time, s, v);
			final_report();
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic look(input int n);
		cyc(n);
		@(negedge core_clk);
	endtask

	// reset events latch high impedance until the enable bit rises
	task automatic rel;
		@(posedge core_clk) driver_enable <= 1'b0;
		@(posedge core_clk) driver_enable <= 1'b1;
		wait_val(line_tip_oe, 1'b1, 6, cnt);
	endtask

	task automatic clr_irq;
		@(posedge core_clk) overcurrent_irq_clear <= 1'b1;
		@(posedge core_clk) overcurrent_irq_clear <= 1'b0;
	endtask

	function automatic logic [6:0] exp_s(input int s, input int i);
		logic [159:0] t;
		if (i < 1 || i > 20)
			return 7'h00;
		t = TMPL[s];
		return t[166 - 8 * i -: 7];
	endfunction

	// ********************************
	// sequence
	// ********************************
	initial
	begin
		{output_enable_pin, hw_reset_pin_n, mclk_run, tclk_run, rst} = 5'h1F;
		{global_soft_reset, channel_soft_reset, driver_enable, overcurrent_hiz_select,
			single_ended_select, tx_power_down, e1_mode, remote_loopback, internal_pattern_line_rate_clock,
			overcurrent_edge_select, overcurrent_irq_mask, overcurrent_irq_clear,
			tmf_show_overcurrent, short_req, mclk_watch_in, tx_system_clock} = '0;
		{tx_positive_rail_in, tx_negative_rail_in} = 2'h3;
		termination_code = 3'h0;
		tx_format = 2'h0;
		pulse_template_select = 4'h0;
		sample_index = 5'h00;
		tclk_div = 2'h0;
		n_errors = 0;
		n_checks = 0;
		cyc(8);
		rst <= 1'b0;
		look(2);
		check(line_tip_oe, 16'h0);
		check(irq_n, 16'h1);
		@(posedge core_clk) driver_enable <= 1'b1;
		wait_val(line_tip_oe, 1'b1, 6, cnt);
		check(line_ring_oe, 16'h1);
		@(posedge core_clk) output_enable_pin <= 1'b0;
		wait_val(line_tip_oe, 1'b0, 6, cnt);
		check(cnt <= 4 && line_ring_oe === 1'b0, 16'h1);
		for (int s = 0; s < 8; s++)
			for (int i = 0; i < 22; i++)
			begin
				@(posedge core_clk);
				pulse_template_select <= s[3:0];
				sample_index <= i[4:0];
				look(1);
				check(sample_value, exp_s(s, i));
			end
		@(posedge core_clk) output_enable_pin <= 1'b1;
		wait_val(line_tip_oe, 1'b1, 6, cnt);
		@(posedge core_clk) driver_enable <= 1'b0;
		wait_val(line_tip_oe, 1'b0, 4, cnt);
		check(cnt <= 2, 16'h1);
		rel;
		@(posedge core_clk);
		single_ended_select <= 1'b1;
		termination_code <= 3'h3;
		look(2);
		check({line_tip_oe, line_ring_oe, config_error}, 16'h4);
		@(posedge core_clk);
		single_ended_select <= 1'b0;
		termination_code <= 3'h7;
		look(2);
		check({line_ring_oe, config_error}, 16'h3);
		@(posedge core_clk);
		termination_code <= 3'h0;
		tmf_show_overcurrent <= 1'b1;
		short_req <= 1'b1;
		wait_val(overcurrent_irq_status, 1'b1, 6, cnt);
		check({overcurrent_live_status, tx_current_limit, line_tip_oe}, 16'h7);
		check(tx_multifunction_out, 16'h1);
		wait_val(irq_n, 1'b0, 3, cnt);
		@(posedge core_clk) overcurrent_irq_mask <= 1'b1;
		look(3);
		check(irq_n, 16'h1);
		@(posedge core_clk) overcurrent_irq_mask <= 1'b0;
		clr_irq;
		look(3);
		check({overcurrent_irq_status, irq_n}, 16'h1);
		@(posedge core_clk) short_req <= 1'b0;
		look(6);
		check({overcurrent_irq_status, overcurrent_live_status}, 16'h0);
		@(posedge core_clk);
		overcurrent_edge_select <= 1'b1;
		short_req <= 1'b1;
		wait_val(overcurrent_irq_status, 1'b1, 6, cnt);
		clr_irq;
		look(3);
		check(overcurrent_irq_status, 16'h0);
		@(posedge core_clk) short_req <= 1'b0;
		wait_val(overcurrent_irq_status, 1'b1, 6, cnt);
		@(posedge core_clk);
		overcurrent_hiz_select <= 1'b1;
		short_req <= 1'b1;
		wait_val(line_tip_oe, 1'b0, 6, cnt);
		check({line_ring_oe, tx_current_limit}, 16'h0);
		@(posedge core_clk) short_req <= 1'b0;
		wait_val(line_tip_oe, 1'b1, 6, cnt);
		@(posedge core_clk) overcurrent_hiz_select <= 1'b0;
		clr_irq;
		@(posedge core_clk) tx_power_down <= 1'b1;
		wait_val(line_tip_oe, 1'b0, 4, cnt);
		look(1);
		check({tx_multifunction_oe, line_tip_out, line_ring_oe}, 16'h0);
		@(posedge core_clk) tx_power_down <= 1'b0;
		wait_val(tx_settling, 1'b1, 4, cnt);
		wait_val(line_tip_oe, 1'b1, PD_LIM + 10, cnt);
		check(cnt >= PD_LIM - 3 && cnt <= PD_LIM + 3 && tx_settling === 1'b0, 16'h1);
		@(posedge core_clk) mclk_run <= 1'b0;
		wait_val(mclk_loss_status, 1'b1, MCLK_LIM + 20, cnt);
		check(cnt >= MCLK_LIM - 1 && cnt <= MCLK_LIM + 6, 16'h1);
		wait_val(line_tip_oe, 1'b0, 3, cnt);
		@(posedge core_clk) mclk_run <= 1'b1;
		wait_val(mclk_loss_status, 1'b0, 8, cnt);
		wait_val(line_tip_oe, 1'b1, 4, cnt);
		for (int m = 0; m < 2; m++)
		begin
			@(posedge core_clk);
			e1_mode <= m[0];
			tx_format <= m[1:0];
			tclk_run <= 1'b0;
			lo = 64 * KHZ / (m ? 2048 : 1544) - 8;
			hi = 65 * KHZ / (m ? 2048 : 1544) + 8;
			wait_val(tx_clock_loss_status, 1'b1, hi + 20, cnt);
			check(cnt >= lo && cnt <= hi, 16'h1);
			wait_val(line_tip_oe, 1'b0, 3, cnt);
			@(posedge core_clk) tclk_run <= 1'b1;
			wait_val(tx_clock_loss_status, 1'b0, 12, cnt);
			wait_val(line_tip_oe, 1'b1, 4, cnt);
			check({line_tip_out, line_ring_out}, m ? 16'h3 : 16'h2);
		end
		for (int k = 0; k < 3; k++)
		begin
			@(posedge core_clk);
			remote_loopback <= (k == 0);
			internal_pattern_line_rate_clock <= (k == 1);
			tx_format <= (k == 2) ? 2'h2 : 2'h0;
			e1_mode <= 1'b0;
			tclk_run <= 1'b0;
			look(9000);
			check({tx_clock_loss_status, line_tip_oe}, 16'h1);
			@(posedge core_clk) tclk_run <= 1'b1;
		end
		@(posedge core_clk);
		{remote_loopback, internal_pattern_line_rate_clock, hw_reset_pin_n} <= 3'h0;
		tx_format <= 2'h0;
		look(100);
		check(line_tip_oe, 16'h1);
		@(posedge core_clk) hw_reset_pin_n <= 1'b1;
		look(5);
		@(posedge core_clk) hw_reset_pin_n <= 1'b0;
		wait_val(line_tip_oe, 1'b0, 430, cnt);
		check(cnt >= 399, 16'h1);
		@(posedge core_clk) hw_reset_pin_n <= 1'b1;
		look(5);
		check(line_tip_oe, 16'h0);
		rel;
		for (int k = 0; k < 2; k++)
		begin
			@(posedge core_clk);
			global_soft_reset <= (k == 0);
			channel_soft_reset <= (k == 1);
			@(posedge core_clk);
			{global_soft_reset, channel_soft_reset} <= 2'h0;
			wait_val(line_tip_oe, 1'b0, 4, cnt);
			look(5);
			check(line_ring_oe, 16'h0);
			rel;
		end
		final_report();
	end
endmodule
